// ==== core/lcis_top.sv ====
// Purpose: Three configurable logic cells with APB registers
// Assumes: Candidates other than cell outputs are external and synchronised here
// Notes:   Outputs registered; cells may cascade via their outputs
// Function
// RULE1: Select, gate, function, polarity stages per cell
// RULE2: Configuration changes take effect while running
// RULE3: Four 32-way input multiplexers per cell
// RULE4: Five-bit code indexes the chosen candidate
// RULE5: Select registers use bits 4:0, rest zero
// RULE6: Software writes selects before trusting output
// RULE7: Codes 31..28 route the four clocks
// RULE8: Codes 27..22 route flag and timer events
// RULE9: Codes 21..16 route serial and zero-cross
// RULE10: Codes 15..8 route modulators, compare, comparators
// RULE11: Codes 6..4 route cell outputs 3..1
// RULE12: Codes 3..0 route the four input pins
// RULE13: Control register enable, output, irq enables, mode
// RULE14: Gates combine picked inputs, then gate invert
// RULE15: Output edges set flags; outputs mirrored
`timescale 1ns/1ps
`include "lcis_defs.svh"
module lcis_top #(
  parameter int NCELL = `LCIS_NCELL
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 fosc,
  input  wire logic                 fast_internal_oscillator,
  input  wire logic                 slow_internal_oscillator,
  input  wire logic                 converter_rc_clock,
  input  wire lcis_pkg::lcis_periph_t periph,
  input  wire logic [3:0]           cell_input_pin,
  output logic      [NCELL-1:0]     cell_output,
  output logic                      irq
);
  import lcis_pkg::*;

  logic [31:0]      cand_meta  [NCELL];
  logic [31:0]      cand_sync  [NCELL];
  logic [31:0]      cand       [NCELL];
  logic [7:0]       con_q      [NCELL];
  logic [7:0]       pol_q      [NCELL];
  logic [4:0]       sel_q      [NCELL][4];
  logic [7:0]       gls_q      [NCELL][4];
  logic [NCELL-1:0] out_q;
  logic [NCELL-1:0] out_prev_q;
  logic [NCELL-1:0] st_q;
  logic [NCELL-1:0] mask_q;
  logic [NCELL-1:0] out_d;
  logic [NCELL-1:0] rise_ev;
  logic [NCELL-1:0] fall_ev;
  logic [NCELL-1:0] irq_set;
  logic [NCELL-1:0] st_clr;
  logic [31:0]      ext_raw;
  logic             wr_en;
  logic             rd_en;

  // Byte address of one cell register
  function automatic logic [11:0] cell_addr(input int c,
                                           input logic [11:0] off);
    cell_addr = off + 12'(c) * `LCIS_CELL_STRIDE;
  endfunction

  // Combine selected true and inverted inputs in one gate
  function automatic logic gate_or(input logic [3:0] d,
                                   input logic [7:0] pick);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = r | (pick[2*i+1] & d[i]) | (pick[2*i] & ~d[i]);
    end
    gate_or = r;
  endfunction

  // Byte address of input select m of cell c
  function automatic logic [11:0] sel_addr(input int c, input int m);
    sel_addr = cell_addr(c, `LCIS_OFF_SEL0 + 12'(m) * `LCIS_WORD_BYTES);
  endfunction

  // Byte address of gate m of cell c
  function automatic logic [11:0] gls_addr(input int c, input int m);
    gls_addr = cell_addr(c, `LCIS_OFF_GLS0 + 12'(m) * `LCIS_WORD_BYTES);
  endfunction

  // Logic function of one cell, q is the present output
  function automatic logic cell_logic(input lcis_mode_t mode,
                                      input logic [3:0] g,
                                      input logic       q);
    logic r;
    r = 1'b0;
    case (mode)
      LCIS_AND_OR: begin
        r = (g[0] & g[1]) | (g[2] & g[3]);
      end
      LCIS_OR_XOR: begin
        r = (g[0] | g[1]) ^ (g[2] | g[3]);
      end
      LCIS_AND4: begin
        r = &g;
      end
      LCIS_SR: begin
        if (g[0] | g[1]) begin
          r = 1'b1;
        end else if (g[2] | g[3]) begin
          r = 1'b0;
        end else begin
          r = q;
        end
      end
      LCIS_DFF_S_R: begin
        if (g[2]) begin
          r = 1'b0;
        end else if (g[3]) begin
          r = 1'b1;
        end else begin
          r = g[1];
        end
      end
      LCIS_DFF2_R: begin
        r = (g[2] | g[3]) ? 1'b0 : g[1];
      end
      LCIS_JK_R: begin
        if (g[2]) begin
          r = 1'b0;
        end else if (g[1] & g[3]) begin
          r = ~q;
        end else if (g[1]) begin
          r = 1'b1;
        end else if (g[3]) begin
          r = 1'b0;
        end else begin
          r = q;
        end
      end
      LCIS_DLAT_S_R: begin
        if (g[2]) begin
          r = 1'b0;
        end else if (g[3]) begin
          r = 1'b1;
        end else if (g[0]) begin
          r = g[1];
        end else begin
          r = q;
        end
      end
      default: begin
        r = 1'b0;
      end
    endcase
    cell_logic = r;
  endfunction

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite & pstrb[0];
  assign rd_en   = psel & ~pwrite;

  // Candidate vector, cell outputs fill in per cell below
  always_comb begin
    ext_raw = '0;
    ext_raw[31] = fosc; // RULE7
    ext_raw[30] = fast_internal_oscillator; // RULE7
    ext_raw[29] = slow_internal_oscillator; // RULE7
    ext_raw[28] = converter_rc_clock; // RULE7
    ext_raw[27] = periph.pin_change_flag; // RULE8
    ext_raw[26:22] = periph.timer_events; // RULE8
    ext_raw[21:20] = periph.async_serial_port; // RULE9
    ext_raw[19] = periph.zero_cross_output; // RULE9
    ext_raw[18] = periph.sync_serial_port[1]; // RULE9
    ext_raw[16] = periph.sync_serial_port[0]; // RULE9
    ext_raw[15:12] = periph.modulator_capture; // RULE10
    ext_raw[11:10] = periph.complementary_out; // RULE10
    ext_raw[9:8] = periph.comparator_output; // RULE10
    ext_raw[3:0] = cell_input_pin; // RULE12
  end

  // Two-stage synchroniser for every outside candidate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        cand_meta[c] <= '0;
        cand_sync[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCELL; c++) begin
        cand_meta[c] <= ext_raw;
        cand_sync[c] <= cand_meta[c];
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      cand[c] = cand_sync[c];
      cand[c][`LCIS_CODE_RSV17] = 1'b0;
      cand[c][`LCIS_CODE_RSV7] = 1'b0;
      for (int k = 0; k < NCELL; k++) begin
        cand[c][4+k] = out_q[k]; // RULE11
      end
    end
  end

  // Per-cell datapath: select, gate, function, polarity
  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      logic [3:0] d;
      logic [3:0] g;
      logic       f;
      d = '0;
      g = '0;
      f = 1'b0;
      for (int m = 0; m < 4; m++) begin
        d[m] = cand[c][sel_q[c][m]]; // RULE3 RULE4
      end
      for (int m = 0; m < 4; m++) begin
        g[m] = gate_or(d, gls_q[c][m]) ^ pol_q[c][m]; // RULE14
      end
      f = cell_logic(lcis_mode_t'(con_q[c][2:0]), g, out_q[c]); // RULE13
      out_d[c] = con_q[c][`LCIS_CON_EN] &
                 (f ^ pol_q[c][`LCIS_POL_OUT]); // RULE1 RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q      <= '0;
      out_prev_q <= '0;
    end else begin
      out_q      <= out_d;
      out_prev_q <= out_q;
    end
  end

  assign cell_output = out_q;

  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      rise_ev[c] = out_q[c] & ~out_prev_q[c];
      fall_ev[c] = ~out_q[c] & out_prev_q[c];
      irq_set[c] = (rise_ev[c] & con_q[c][`LCIS_CON_INTP]) |
                   (fall_ev[c] & con_q[c][`LCIS_CON_INTN]); // RULE15
    end
  end

  always_comb begin
    st_clr = '0;
    if (wr_en && paddr == `LCIS_OFF_IRQ_STAT) begin
      st_clr = pwdata[NCELL-1:0];
    end
  end

  // Sticky flags, a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= (st_q & ~st_clr) | irq_set; // RULE15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_en && paddr == `LCIS_OFF_IRQ_MASK) begin
      mask_q <= pwdata[NCELL-1:0];
    end
  end

  assign irq = |(st_q & mask_q);

  // Control register, live output bit is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        con_q[c] <= `LCIS_RST_BYTE;
      end
    end else if (wr_en) begin
      for (int c = 0; c < NCELL; c++) begin
        if (paddr == cell_addr(c, `LCIS_OFF_CON)) begin
          con_q[c] <= pwdata[7:0] & `LCIS_CON_WMASK; // RULE13 RULE2
        end
      end
    end
  end

  // Output and gate inversion bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        pol_q[c] <= `LCIS_RST_BYTE;
      end
    end else if (wr_en) begin
      for (int c = 0; c < NCELL; c++) begin
        if (paddr == cell_addr(c, `LCIS_OFF_POL)) begin
          pol_q[c] <= pwdata[7:0] & `LCIS_POL_WMASK; // RULE2
        end
      end
    end
  end

  // Input select codes, five bits stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        for (int m = 0; m < 4; m++) begin
          sel_q[c][m] <= '0;
        end
      end
    end else if (wr_en) begin
      for (int c = 0; c < NCELL; c++) begin
        for (int m = 0; m < 4; m++) begin
          if (paddr == sel_addr(c, m)) begin
            sel_q[c][m] <= pwdata[4:0]; // RULE5 RULE2
          end
        end
      end
    end
  end

  // Gate input picks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        for (int m = 0; m < 4; m++) begin
          gls_q[c][m] <= `LCIS_RST_BYTE;
        end
      end
    end else if (wr_en) begin
      for (int c = 0; c < NCELL; c++) begin
        for (int m = 0; m < 4; m++) begin
          if (paddr == gls_addr(c, m)) begin
            gls_q[c][m] <= pwdata[7:0]; // RULE14
          end
        end
      end
    end
  end

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      prdata <= '0;
      if (paddr == `LCIS_OFF_DATA) begin
        prdata <= 32'(out_q); // RULE15
      end else if (paddr == `LCIS_OFF_IRQ_STAT) begin
        prdata <= 32'(st_q);
      end else if (paddr == `LCIS_OFF_IRQ_MASK) begin
        prdata <= 32'(mask_q);
      end
      for (int c = 0; c < NCELL; c++) begin
        if (paddr == cell_addr(c, `LCIS_OFF_CON)) begin
          prdata <= 32'(con_q[c] | (8'(out_q[c]) << `LCIS_CON_OUT));
        end else if (paddr == cell_addr(c, `LCIS_OFF_POL)) begin
          prdata <= 32'(pol_q[c]);
        end
        for (int m = 0; m < 4; m++) begin
          if (paddr == sel_addr(c, m)) begin
            prdata <= 32'(sel_q[c][m]); // RULE5
          end else if (paddr == gls_addr(c, m)) begin
            prdata <= 32'(gls_q[c][m]);
          end
        end
      end
    end
  end
endmodule

// ==== shared/lcis_defs.svh ====
// Purpose: Register offsets, field positions and reset values
// Assumes: APB byte addresses, one register per aligned word
// Notes:   Offsets are local to this block
`ifndef LCIS_DEFS_SVH
`define LCIS_DEFS_SVH
`define LCIS_NCELL        3
`define LCIS_OFF_CON      12'h000
`define LCIS_OFF_POL      12'h004
`define LCIS_OFF_SEL0     12'h008
`define LCIS_OFF_GLS0     12'h018
`define LCIS_CELL_STRIDE  12'h040
`define LCIS_OFF_DATA     12'h100
`define LCIS_OFF_IRQ_STAT 12'h104
`define LCIS_OFF_IRQ_MASK 12'h108
`define LCIS_CON_EN       7
`define LCIS_CON_OUT      5
`define LCIS_CON_INTP     4
`define LCIS_CON_INTN     3
`define LCIS_POL_OUT      7
`define LCIS_RST_BYTE     8'h00
`define LCIS_CON_WMASK    8'h9f
`define LCIS_POL_WMASK    8'h8f
`define LCIS_WORD_BYTES   12'h004
`define LCIS_CODE_RSV7    5'h07
`define LCIS_CODE_RSV17   5'h11
`endif

// ==== shared/lcis_pkg.sv ====
// Purpose: Types for the logic cell block
// Assumes: lcis_defs.svh for numeric constants
// Notes:   Candidate vector index equals select code
package lcis_pkg;
  typedef enum logic [2:0] {
    LCIS_AND_OR, LCIS_OR_XOR, LCIS_AND4, LCIS_SR,
    LCIS_DFF_S_R, LCIS_DFF2_R, LCIS_JK_R, LCIS_DLAT_S_R
  } lcis_mode_t;
  typedef struct packed {
    logic       enable;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    lcis_mode_t function_mode;
  } lcis_ctrl_t;
  typedef struct packed {
    logic [1:0] fosc_fast;
    logic [1:0] slow_rc;
    logic       pin_change_flag;
    logic [4:0] timer_events;
    logic [1:0] async_serial_port;
    logic       zero_cross_output;
    logic [1:0] sync_serial_port;
    logic [3:0] modulator_capture;
    logic [1:0] complementary_out;
    logic [1:0] comparator_output;
  } lcis_periph_t;
endpackage

// ==== testbench/lcis_properties.sv ====
// Purpose: Port-level checks for lcis_top
// Assumes: Cell c registers at 0x40*c, c counted from 0
// Notes:   Bound to every lcis_top instance
`timescale 1ns/1ps
module lcis_properties #(
  parameter int NCELL = 3
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [NCELL-1:0] cell_output,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       rd;
  logic       cell_rd;
  logic [5:0] off;
  assign rd = psel && penable && !pwrite;
  assign cell_rd = rd && paddr[11:8] == 4'h0 && paddr[7:6] != 2'h3;
  assign off = paddr[5:0];
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_slverr: assert property (!pslverr)
    else $error("pslverr raised");
  a_sel_upper: assert property (
    cell_rd && off inside {6'h08, 6'h0c, 6'h10, 6'h14}
    |-> prdata[31:5] == 27'h0) else $error("select upper bits set");
  a_ctrl_bits: assert property (
    cell_rd && off == 6'h00 |-> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("control reserved bits set");
  a_gate_byte: assert property (
    cell_rd && off >= 6'h18 && off <= 6'h24 |-> prdata[31:8] == 24'h0)
    else $error("gate upper bits set");
  a_pol_bits: assert property (
    cell_rd && off == 6'h04 |-> prdata[6:4] == 3'h0)
    else $error("polarity reserved bits set");
  a_mirror_out: assert property (
    rd && paddr == 12'h100 |-> prdata[2:0] == $past(cell_output)
    && prdata[31:3] == 29'h0) else $error("mirror mismatch");
  a_mask_off: assert property (
    psel && penable && pwrite && pstrb[0] && paddr == 12'h108
    && pwdata[2:0] == 3'h0 |=> !irq) else $error("irq while masked");
  c_ctrl_wr: cover property (psel && penable && pwrite && paddr == 12'h0);
  c_irq: cover property ($rose(irq));
  c_cascade: cover property ($rose(cell_output[1]));
endmodule
bind lcis_top lcis_properties #(.NCELL(NCELL)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cell_output(cell_output), .irq(irq)
);

// ==== testbench/lcis_src.sv ====
// Purpose: Candidate signal sources around the cells
// Assumes: Bit k of cand is candidate k
// Notes:   Spare fields get inverted clock bits
`timescale 1ns/1ps
module lcis_src (
  input  wire logic [31:0]        cand,
  output logic                    fosc,
  output logic                    fast_osc,
  output logic                    slow_osc,
  output logic                    rc_clk,
  output lcis_pkg::lcis_periph_t  periph,
  output logic [3:0]              pins
);
  import lcis_pkg::*;
  assign fosc = cand[31];
  assign fast_osc = cand[30];
  assign slow_osc = cand[29];
  assign rc_clk = cand[28];
  assign periph = {~cand[31:28],
                   cand[27:22],
                   cand[21:18], cand[16],
                   cand[15:8]};
  assign pins = cand[3:0];
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for lcis_top
// Assumes: Cell c registers at 0x40*c, c counted from 0
// Notes:   Every cell is set up as a four-way AND of input zero
`timescale 1ns/1ps
`include "lcis_defs.svh"
module tb_top;
  import lcis_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h0;
  logic [31:0]   pwdata = 32'h0;
  logic [3:0]    pstrb = 4'h0;
  logic [31:0]   cand = 32'h0;
  logic [31:0]   prdata, rd_q;
  logic          pready, pslverr, irq, fo, fi, si, rc;
  logic [2:0]    outs;
  lcis_periph_t  periph;
  logic [3:0]    pins;
  int            mismatches = 0;
  int            num_checks = 0;
  int            cycles = 0;
  always #2.5 pclk = ~pclk;
  lcis_src src (.cand(cand), .fosc(fo), .fast_osc(fi), .slow_osc(si),
    .rc_clk(rc), .periph(periph), .pins(pins));
  lcis_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fosc(fo), .fast_internal_oscillator(fi), .slow_internal_oscillator(si),
    .converter_rc_clock(rc), .periph(periph), .cell_input_pin(pins),
    .cell_output(outs), .irq(irq));
  task results;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (10) @(posedge pclk);
  endtask
  task cfg(input int c, input logic [4:0] code);
    for (int g = 0; g < 4; g++) apb(1'b1, 12'(c * 64 + 24 + 4 * g), 32'h2);
    apb(1'b1, 12'(c * 64 + 8), {27'h0, code});
    apb(1'b1, 12'(c * 64), 32'h82);
  endtask
  task t_regs;
    logic [11:0] a [8] = '{12'h000, 12'h004, 12'h008, 12'h018,
                           12'h100, 12'h104, 12'h108, 12'h0fc};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd_q, 32'h0);
    end
    apb(1'b1, `LCIS_OFF_SEL0, 32'hff);
    apb(1'b0, `LCIS_OFF_SEL0, 32'h0);
    chk(rd_q, 32'h1f);
  endtask
  task t_codes;
    logic e;
    cfg(0, 5'h0);
    for (int k = 0; k < 32; k++) begin
      if (k inside {[4:6]}) continue;
      e = !(k == 7 || k == 17);
      apb(1'b1, `LCIS_OFF_SEL0, k);
      cand <= e ? (32'h1 << k) : 32'hffffffff;
      settle();
      chk({31'h0, outs[0]}, {31'h0, e});
      cand <= ~(32'h1 << k);
      settle();
      chk({31'h0, outs[0]}, 32'h0);
    end
  endtask
  task t_cascade;
    cfg(2, 5'h0);
    cfg(1, 5'h06);
    cfg(0, 5'h05);
    cand <= 32'h1;
    settle();
    chk({29'h0, outs}, 32'h7);
    apb(1'b1, `LCIS_OFF_SEL0, 32'h0);
    apb(1'b1, 12'h048, 32'h04);
    apb(1'b1, 12'h088, 32'h05);
    cand <= 32'h0;
    settle();
    chk({29'h0, outs}, 32'h0);
    cand <= 32'h1;
    settle();
    apb(1'b0, `LCIS_OFF_DATA, 32'h0);
    chk(rd_q, 32'h7);
  endtask
  task t_pol;
    cfg(0, 5'h0);
    apb(1'b1, `LCIS_OFF_POL, 32'h80);
    settle();
    chk({31'h0, outs[0]}, 32'h0);
    apb(1'b1, `LCIS_OFF_POL, 32'h01);
    settle();
    chk({31'h0, outs[0]}, 32'h0);
    cand <= 32'h0;
    apb(1'b1, `LCIS_OFF_POL, 32'h0f);
    settle();
    chk({31'h0, outs[0]}, 32'h1);
    apb(1'b0, `LCIS_OFF_CON, 32'h0);
    chk(rd_q, 32'ha2);
    apb(1'b1, `LCIS_OFF_CON, 32'h02);
    settle();
    chk({31'h0, outs[0]}, 32'h0);
    apb(1'b1, `LCIS_OFF_POL, 32'h0);
  endtask
  task t_irq;
    cfg(0, 5'h0);
    cand <= 32'h0;
    settle();
    apb(1'b1, `LCIS_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `LCIS_OFF_IRQ_MASK, 32'h1);
    apb(1'b1, `LCIS_OFF_CON, 32'h92);
    cand <= 32'h1;
    settle();
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `LCIS_OFF_IRQ_MASK, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `LCIS_OFF_IRQ_STAT, 32'h0);
    chk(rd_q, 32'h1);
    apb(1'b1, `LCIS_OFF_IRQ_STAT, 32'h1);
    apb(1'b1, `LCIS_OFF_CON, 32'h8a);
    apb(1'b0, `LCIS_OFF_IRQ_STAT, 32'h0);
    chk(rd_q, 32'h0);
    cand <= 32'h0;
    settle();
    apb(1'b0, `LCIS_OFF_IRQ_STAT, 32'h0);
    chk(rd_q, 32'h1);
    apb(1'b1, `LCIS_OFF_IRQ_STAT, 32'h1);
    cand <= 32'h1;
    settle();
    apb(1'b0, `LCIS_OFF_IRQ_STAT, 32'h0);
    chk(rd_q, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_codes();
    t_cascade();
    t_pol();
    t_irq();
    results();
  end
endmodule
